// file: rtl/ssf_top.sv
// status flag logic of one serial channel with avalon register slave
// What this block does
// - smart card select switches bit 4 and transmit-end meaning
// - smart card: error line sampled low during transmit sets error flag
// - error flag clears on reset, standby, or write 0 after read as 1
// - clearing transmit enable leaves the error flag alone
// - async with parity: mismatching parity sets parity error flag
// - parity flag clears on reset, standby, or write 0 after read as 1
// - clearing receive enable leaves the parity flag alone
// - parity error: character still loaded, buffer-full not raised
// - parity flag stalls reception; in sync mode transmission too
// - normal mode: end flag set by reset, standby, enable off, last bit
// - end flag cleared when software clears the buffer-empty flag
// - end flag is read only
// - smart card: end flag set 2.5 or 1.0 bit times after send
// - smart card: enable off with error flag 0 sets end flag
// - bit time is measured as one transmitted bit
// - received multiprocessor bit captured in async mp format, read only
// - receive enable off holds received multiprocessor bit
// - transmit multiprocessor bit appended in async mp format
// - transmit multiprocessor bit ignored otherwise
// - reset: mp bits and error flags 0, end flag 1
// - error flags: writes of 1 ignored; write 0 clears only after read while set
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ssf_top
  import ssf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic standby,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transmit side of the shifter
  input wire logic tx_bit_tick,
  input wire logic tx_last_bit,
  input wire logic transmit_buffer_empty_flag,
  input wire logic transmit_buffer_empty_flag_clear,
  input wire logic sc_err_sample,
  input wire logic sc_err_line,
  // receive side of the shifter
  input wire ssf_rx_char_t rx_char,
  // outputs to the datapath
  output logic rx_load,
  output logic rx_set_full,
  output logic rx_stall,
  output logic tx_stall,
  output logic tx_mpb_out,
  output logic transmit_end_out
);
  ssf_ctrl_t ctrl_ff;
  ssf_bus_st_t st_ff;
  ssf_bus_st_t nxt_st;
  logic ers_ff;
  logic per_ff;
  logic transmit_end_flag_ff;
  logic mpb_ff;
  logic transmit_multiproc_bit_ff;
  logic ers_arm_ff;
  logic per_arm_ff;
  logic [31:0] rdata_ff;
  logic wait_ff;
  logic rx_load_ff;
  logic rx_full_ff;
  logic rx_stall_ff;
  logic tx_stall_ff;
  logic tx_mpb_ff;
  logic [7:0] status_view;
  logic wr_hit;
  logic rd_hit;
  logic wr_status;
  logic wr_control;
  logic te_fall;
  logic par_bad;
  logic rx_ok;
  logic ers_set;
  logic per_set;
  logic sc_start;
  logic sc_expire;
  logic [ETU_W-1:0] etu_len;
  logic clr_state;
  ssf_ctrl_t nxt_ctrl;

  // standby clears the flags as a reset does
  assign clr_state = !rst_n || standby;

  // bus handshake: two wait cycles, then the ack cycle
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: if (avs_read || avs_write) nxt_st = ST_WAIT;
      ST_WAIT: nxt_st = ST_ACK;
      ST_ACK: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      wait_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      wait_ff <= (nxt_st != ST_ACK);
    end
  end

  // writes take effect at the edge the master sees waitrequest low
  assign wr_hit = avs_write && (st_ff == ST_ACK);
  // read data is latched one edge before that
  assign rd_hit = avs_read && (st_ff == ST_WAIT);
  assign wr_status = wr_hit && avs_address == ADDR_STATUS
    && avs_byteenable[0];
  assign wr_control = wr_hit && avs_address == ADDR_CONTROL
    && avs_byteenable[0];

  assign status_view = {3'b000, ers_ff, per_ff, transmit_end_flag_ff, mpb_ff, transmit_multiproc_bit_ff};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_ff <= RD_ZERO;
    end else if (rd_hit) begin
      unique case (avs_address)
        ADDR_STATUS: rdata_ff <= {24'h00_0000, status_view};
        ADDR_CONTROL: rdata_ff <= {24'h00_0000, ctrl_ff};
        ADDR_ETU: rdata_ff <= {16'h0000, etu_len};
        default: rdata_ff <= RD_ZERO;
      endcase
    end
  end

  // control register
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_control) nxt_ctrl = ssf_ctrl_t'(avs_writedata[CTRL_W-1:0]);
  end

  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      ctrl_ff <= ssf_ctrl_t'(CTRL_RST);
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign te_fall = ctrl_ff.transmit_enable && !nxt_ctrl.transmit_enable;

  // arm a clear only when software has seen the flag set
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      ers_arm_ff <= 1'b0;
      per_arm_ff <= 1'b0;
    end else if (rd_hit && avs_address == ADDR_STATUS) begin
      ers_arm_ff <= ers_ff;
      per_arm_ff <= per_ff;
    end else if (wr_status) begin
      ers_arm_ff <= 1'b0;
      per_arm_ff <= 1'b0;
    end
  end

  // smart card error signal flag, bit 4 in smart card mode
  assign ers_set = ctrl_ff.smart_card_mode_select && sc_err_sample
    && !sc_err_line;

  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      ers_ff <= 1'b0;
    end else if (ers_set) begin
      ers_ff <= 1'b1; // set beats a same-cycle clear
    end else if (wr_status && ers_arm_ff && !avs_writedata[BIT_ERS]) begin
      ers_ff <= 1'b0;
    end
    // transmit enable is not a term here
  end

  // parity check on each received character
  ssf_parity_chk u_par (
    .data(rx_char.data),
    .parity_bit(rx_char.parity_bit),
    .odd_select(ctrl_ff.parity_odd_select),
    .mismatch(par_bad)
  );

  assign per_set = rx_char.done && ctrl_ff.receive_enable
    && !rx_stall_ff && !ctrl_ff.sync_mode && ctrl_ff.parity_enable
    && par_bad;
  assign rx_ok = rx_char.done && ctrl_ff.receive_enable && !rx_stall_ff;

  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      per_ff <= 1'b0;
    end else if (per_set) begin
      per_ff <= 1'b1;
    end else if (wr_status && per_arm_ff && !avs_writedata[BIT_PER]) begin
      per_ff <= 1'b0;
    end
    // receive enable is not a term here
  end

  // character moves to the buffer unless receive is off or stalled; full only when clean
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      rx_load_ff <= 1'b0;
      rx_full_ff <= 1'b0;
    end else begin
      rx_load_ff <= rx_ok;
      rx_full_ff <= rx_ok && !per_set;
    end
  end

  // the error holds off the receiver, and in sync mode the transmitter, until software clears it
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      rx_stall_ff <= 1'b0;
      tx_stall_ff <= 1'b0;
    end else begin
      rx_stall_ff <= per_ff || per_set;
      tx_stall_ff <= (per_ff || per_set) && ctrl_ff.sync_mode;
    end
  end

  // guard-time timer for smart card end of transmission
  assign sc_start = ctrl_ff.smart_card_mode_select && tx_last_bit
    && transmit_buffer_empty_flag && !ers_ff;

  ssf_etu_timer u_etu (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bit_tick(tx_bit_tick),
    .start(sc_start),
    .cancel(ers_set || standby || transmit_buffer_empty_flag_clear),
    .guard_mode(ctrl_ff.block_guard_mode),
    .etu_len(etu_len),
    .expire(sc_expire)
  );

  // transmit end flag; status register writes never reach it
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      transmit_end_flag_ff <= 1'b1;
    end else if (!ctrl_ff.smart_card_mode_select) begin
      if (te_fall) begin
        transmit_end_flag_ff <= 1'b1;
      end else if (tx_last_bit && transmit_buffer_empty_flag) begin
        transmit_end_flag_ff <= 1'b1;
      end else if (transmit_buffer_empty_flag_clear) begin
        transmit_end_flag_ff <= 1'b0;
      end
    end else begin
      if (te_fall && !ers_ff) begin
        transmit_end_flag_ff <= 1'b1;
      end else if (sc_expire && !ers_ff) begin
        transmit_end_flag_ff <= 1'b1;
      end else if (transmit_buffer_empty_flag_clear) begin
        transmit_end_flag_ff <= 1'b0;
      end
    end
  end

  // received multiprocessor bit, read only
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      mpb_ff <= 1'b0;
    end else if (rx_ok && ctrl_ff.multiproc_format
        && !ctrl_ff.sync_mode) begin
      mpb_ff <= rx_char.multiproc_bit;
    end
  end

  // transmit multiprocessor bit, software owned
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      transmit_multiproc_bit_ff <= 1'b0;
    end else if (wr_status) begin
      transmit_multiproc_bit_ff <= avs_writedata[BIT_TRANSMIT_MULTIPROC_BIT];
    end
  end

  // only meaningful for async mp format with a working transmitter
  always_ff @(posedge clk_sys) begin
    if (clr_state) begin
      tx_mpb_ff <= 1'b0;
    end else begin
      tx_mpb_ff <= transmit_multiproc_bit_ff && ctrl_ff.multiproc_format
        && !ctrl_ff.sync_mode && ctrl_ff.transmit_enable
        && !tx_stall_ff;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign rx_load = rx_load_ff;
  assign rx_set_full = rx_full_ff;
  assign rx_stall = rx_stall_ff;
  assign tx_stall = tx_stall_ff;
  assign tx_mpb_out = tx_mpb_ff;
  assign transmit_end_out = transmit_end_flag_ff;
endmodule : ssf_top
`default_nettype wire

// file: rtl/ssf_pkg.sv
// shared constants and types for the serial status flag block
package ssf_pkg;
  // avalon word addresses (address port counts words)
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_ETU = 2'h2;
  // status bit positions
  localparam int BIT_TRANSMIT_MULTIPROC_BIT = 0;
  localparam int BIT_MPB = 1;
  localparam int BIT_TRANSMIT_END_FLAG = 2;
  localparam int BIT_PER = 3;
  localparam int BIT_ERS = 4;
  // control bit positions
  localparam int CB_TE = 0;
  localparam int CB_RE = 1;
  localparam int CB_SMART_CARD_MODE_SELECT = 2;
  localparam int CB_GM = 3;
  localparam int CB_PEN = 4;
  localparam int CB_ODD = 5;
  localparam int CB_MP = 6;
  localparam int CB_SYNC = 7;
  localparam int CTRL_W = 8;
  localparam int ETU_W = 16;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [ETU_W-1:0] ETU_RST = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [ETU_W+1:0] CNT_ZERO = 18'h0_0000;
  localparam logic [ETU_W+1:0] CNT_ONE = 18'h0_0001;
  localparam logic [ETU_W-1:0] ETU_ONE = 16'h0001;
  localparam logic [ETU_W-1:0] ETU_MAX = 16'hffff;

  typedef struct packed {
    logic sync_mode;
    logic multiproc_format;
    logic parity_odd_select;
    logic parity_enable;
    logic block_guard_mode;
    logic smart_card_mode_select;
    logic receive_enable;
    logic transmit_enable;
  } ssf_ctrl_t;

  typedef struct packed {
    logic done;
    logic [7:0] data;
    logic parity_bit;
    logic multiproc_bit;
  } ssf_rx_char_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK = 3'b100
  } ssf_bus_st_t;
endpackage : ssf_pkg

// file: rtl/ssf_parity_chk.sv
// parity check of one received character
`timescale 1ns/100ps
`default_nettype none
module ssf_parity_chk
  import ssf_pkg::*;
(
  // character in
  input wire logic [7:0] data,
  input wire logic parity_bit,
  input wire logic odd_select,
  // result
  output logic mismatch
);
  logic [8:0] acc;
  assign acc[0] = parity_bit;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_xor
      assign acc[i+1] = acc[i] ^ data[i];
    end
  endgenerate
  // even: total ones must be even; odd: must be odd
  assign mismatch = acc[8] ^ odd_select;
endmodule : ssf_parity_chk
`default_nettype wire

// file: rtl/ssf_etu_timer.sv
// bit time measurement and smart card end-of-transmit delay
`timescale 1ns/100ps
`default_nettype none
module ssf_etu_timer
  import ssf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic bit_tick,
  input wire logic start,
  input wire logic cancel,
  input wire logic guard_mode,
  // results
  output logic [ETU_W-1:0] etu_len,
  output logic expire
);
  logic [ETU_W-1:0] meas_ff;
  logic [ETU_W-1:0] etu_ff;
  logic [ETU_W+1:0] cnt_ff;
  logic [ETU_W+1:0] target;
  logic busy_ff;
  logic expire_ff;

  // one etu is the spacing of transmitted bit ticks
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meas_ff <= ETU_RST;
      etu_ff <= ETU_RST;
    end else if (bit_tick) begin
      meas_ff <= ETU_ONE;
      etu_ff <= meas_ff;
    end else if (meas_ff != ETU_MAX) begin
      meas_ff <= meas_ff + ETU_ONE;
    end
  end

  // 2.5 etu is etu*2 + etu/2, rounded down
  assign target = guard_mode ? {2'b00, etu_ff}
    : ({1'b0, etu_ff, 1'b0} + {3'b000, etu_ff[ETU_W-1:1]});

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cancel) begin
      busy_ff <= 1'b0;
      cnt_ff <= CNT_ZERO;
      expire_ff <= 1'b0;
    end else if (start) begin
      busy_ff <= 1'b1;
      cnt_ff <= CNT_ONE;
      expire_ff <= 1'b0;
    end else if (busy_ff && cnt_ff >= target) begin
      busy_ff <= 1'b0;
      expire_ff <= 1'b1;
    end else begin
      cnt_ff <= busy_ff ? cnt_ff + CNT_ONE : cnt_ff;
      expire_ff <= 1'b0;
    end
  end

  assign etu_len = etu_ff;
  assign expire = expire_ff;
endmodule : ssf_etu_timer
`default_nettype wire

// file: dv/ssf_monitor.sv
// assertion checker for the serial status flag block
`timescale 1ns/100ps
`default_nettype none
module ssf_monitor
  import ssf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic standby,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // datapath
  input wire logic transmit_buffer_empty_flag_clear,
  input wire ssf_rx_char_t rx_char,
  input wire logic rx_load,
  input wire logic rx_set_full,
  input wire logic rx_stall,
  input wire logic tx_stall,
  input wire logic tx_mpb_out,
  input wire logic transmit_end_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // two waiting edges, then one ack edge
  sequence s_ack;
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // standby held long enough for registered outputs to follow
  sequence s_stby;
    standby [*3];
  endsequence
  property p_ack;
    $rose(avs_read || avs_write) |-> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer mistimed");
  property p_load_lat;
    rx_load |-> $past(rx_char.done);
  endproperty
  a_load_lat: assert property (p_load_lat)
    else $error("load w/o char");
  property p_full_load;
    rx_set_full |-> rx_load;
  endproperty
  a_full_load: assert property (p_full_load)
    else $error("full w/o load");
  property p_err_stall;
    rx_load && !rx_set_full |-> rx_stall;
  endproperty
  a_err_stall: assert property (p_err_stall)
    else $error("no stall");
  // writes may clear the flag; allow one cycle of lag after them
  property p_stall_hold;
    rx_stall && !standby && !avs_write && !$past(avs_write)
      && !$past(standby) |=> rx_stall;
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("stall lost");
  property p_tx_stall;
    tx_stall |-> rx_stall;
  endproperty
  a_tx_stall: assert property (p_tx_stall)
    else $error("tx stall alone");
  property p_transmit_end_flag_hold;
    transmit_end_out && !transmit_buffer_empty_flag_clear |=> transmit_end_out;
  endproperty
  a_transmit_end_flag_hold: assert property (p_transmit_end_flag_hold)
    else $error("end flag lost");
  property p_rst_vals;
    $rose(rst_n) |-> transmit_end_out && !tx_mpb_out
      && !rx_stall && !tx_stall;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset values");
  property p_stby;
    s_stby |-> transmit_end_out && !rx_stall && !tx_stall && !tx_mpb_out;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby values");
endmodule : ssf_monitor
bind ssf_top ssf_monitor u_mon (.*);
`default_nettype wire

// file: dv/ssf_card_model.sv
// far-side serial partner: characters and the card error signal
`timescale 1ns/100ps
`default_nettype none
module ssf_card_model
  import ssf_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // commands from the bench
  input wire logic rd_send,
  input wire logic rd_nack,
  input wire logic [7:0] rd_d,
  input wire logic rd_bad,
  input wire logic rd_mpb,
  // lines toward the device
  output var ssf_rx_char_t rx_char,
  output logic sc_err_sample,
  output logic sc_err_line
);
  // even parity unless told to corrupt it; data toggles when idle
  always_ff @(posedge clk_sys) begin
    rx_char.done <= rd_send;
    rx_char.data <= rd_send ? rd_d : ~rx_char.data;
    rx_char.parity_bit <= ^rd_d ^ rd_bad;
    rx_char.multiproc_bit <= rd_mpb;
  end
  // pulled-up error line, low only for a refused character
  always_ff @(posedge clk_sys) begin
    sc_err_sample <= rd_nack;
    sc_err_line <= !rd_nack;
  end
endmodule : ssf_card_model
`default_nettype wire

// file: dv/ssf_top_tb.sv
// testbench for the serial status flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); \
  end \
end
module ssf_top_tb
  import ssf_pkg::*;
;
  // clock, reset and bus
  logic clk_sys = 1'b0, rst_n = 1'b0, standby = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  // shifter and partner side
  logic [4:0] pl = 5'h00;
  logic transmit_buffer_empty_flag = 1'b1, rd_bad = 1'b0, rd_mpb = 1'b0;
  logic [7:0] rd_d = 8'h00, q;
  wire tx_bit_tick = pl[0];
  wire tx_last_bit = pl[1];
  wire transmit_buffer_empty_flag_clear = pl[2];
  wire rd_send = pl[3];
  wire rd_nack = pl[4];
  logic sc_err_sample, sc_err_line, rx_load, rx_set_full, rx_stall;
  logic tx_stall, tx_mpb_out, transmit_end_out;
  ssf_rx_char_t rx_char;
  int errors = 0, samples_checked = 0;
  ssf_top dut (.*);
  ssf_card_model partner (.*);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // one avalon access; q holds read data
  task automatic bus(input logic wr, input logic [1:0] a,
      input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : bus
  // spacing of four cycles also fixes the bit time at 4
  task automatic pls(input int i);
    pl[i] <= 1'b1;
    @(posedge clk_sys);
    pl[i] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : pls
  task automatic rx(input logic [7:0] d, input logic b, input logic m);
    rd_d <= d;
    rd_bad <= b;
    rd_mpb <= m;
    pls(3);
  endtask : rx
  // loose window: exact lag is the designer's, the bit count is not
  task automatic sc_end(input int t);
    int n;
    n = 0;
    pls(2);
    `CHK(transmit_end_out, 1'b0)
    repeat (3) pls(0);
    pls(1);
    while (transmit_end_out !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n + 3 >= t && n + 3 <= t + 5, 1'b1)
  endtask : sc_end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h04)
    bus(0, 2'h3, 8'h00);
    `CHK(q, 8'h00)
    bus(1, ADDR_STATUS, 8'h1f);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h05)
    bus(1, ADDR_CONTROL, 8'h41);
    `CHK(tx_mpb_out, 1'b1)
    bus(1, ADDR_CONTROL, 8'hc1);
    `CHK(tx_mpb_out, 1'b0)
    bus(1, ADDR_STATUS, 8'h00);
    bus(1, ADDR_CONTROL, 8'h52);
    rx(8'h03, 1'b0, 1'b1);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h06)
    rx(8'h01, 1'b1, 1'b1);
    `CHK(rx_stall, 1'b1)
    bus(1, ADDR_STATUS, 8'h00);
    bus(1, ADDR_CONTROL, 8'h50);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h0e)
    bus(1, ADDR_CONTROL, 8'hd0);
    `CHK(tx_stall, 1'b1)
    bus(1, ADDR_CONTROL, 8'h50);
    bus(1, ADDR_STATUS, 8'h00);
    `CHK(rx_stall, 1'b0)
    rx(8'h00, 1'b0, 1'b0);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h06)
    bus(1, ADDR_CONTROL, 8'h05);
    pls(2);
    pls(4);
    bus(1, ADDR_CONTROL, 8'h04);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h12)
    bus(1, ADDR_STATUS, 8'h00);
    bus(1, ADDR_CONTROL, 8'h05);
    bus(1, ADDR_CONTROL, 8'h04);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h06)
    bus(1, ADDR_CONTROL, 8'h05);
    sc_end(10);
    bus(1, ADDR_CONTROL, 8'h0d);
    sc_end(4);
    bus(0, ADDR_ETU, 8'h00);
    `CHK(q, 8'h04)
    bus(1, ADDR_CONTROL, 8'h01);
    pls(2);
    transmit_buffer_empty_flag <= 1'b0;
    pls(1);
    `CHK(transmit_end_out, 1'b0)
    transmit_buffer_empty_flag <= 1'b1;
    pls(1);
    `CHK(transmit_end_out, 1'b1)
    pls(2);
    bus(1, ADDR_CONTROL, 8'h00);
    `CHK(transmit_end_out, 1'b1)
    bus(1, ADDR_STATUS, 8'h01);
    standby <= 1'b1;
    repeat (3) @(posedge clk_sys);
    standby <= 1'b0;
    @(posedge clk_sys);
    bus(0, ADDR_STATUS, 8'h00);
    `CHK(q, 8'h04)
    conclude();
  end
endmodule : ssf_top_tb
`default_nettype wire
